//--- bench/cp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cp_core_model
(
    input wire logic clk,
    input wire mmu_regs_pkg::cp_rsp_t rsp,
    output var mmu_regs_pkg::cp_req_t req
);
    import mmu_regs_pkg::*;
    initial req = '0;
    // held through its taking edge; data inverted once released
    task automatic put(input logic w, input logic [3:0] num, input logic [2:0] op2,
                       input logic [31:0] d);
        @(posedge clk);
        #1;
        req = '{valid: 1'b1, write: w, coprocessor_reg_number: num, crm: 4'h0,
                op2: op2, wdata: d};
        @(posedge clk);
        #1;
        req.valid = 1'b0;
        req.wdata = ~d;
    endtask
    task automatic read(input logic [3:0] num, input logic [2:0] op2,
                        output logic [31:0] d, output bit ok);
        put(1'b0, num, op2, ~req.wdata);
        ok = 1'b0;
        d = 'x;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            if (rsp.valid === 1'b1)
            begin
                ok = 1'b1;
                d = rsp.rdata;
            end
            else
                @(posedge clk) #1;
        end
    endtask
endmodule
`default_nettype wire

//--- bench/mmu_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mmu_regs_sva
(
    input wire logic clk,
    input wire logic reset,
    input wire mmu_regs_pkg::cp_req_t req,
    input wire mmu_regs_pkg::cp_rsp_t rsp,
    input wire logic [31:0] lookup_addr,
    input wire logic use_base_high,
    input wire mmu_regs_pkg::mmu_cfg_t cfg,
    input wire mmu_regs_pkg::maint_cmd_t cache_cmd,
    input wire mmu_regs_pkg::maint_cmd_t tlb_cmd
);
    import mmu_regs_pkg::*;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic wr_tlb;
    logic wr_cache;
    logic rd_maint;
    assign wr = req.valid && req.write;
    assign rd = req.valid && !req.write;
    assign wr_ctrl = wr && req.coprocessor_reg_number == REG_CTRL && req.op2 == OP2_0;
    assign wr_tlb = wr && req.coprocessor_reg_number == REG_TLB;
    assign wr_cache = wr && req.coprocessor_reg_number == REG_CACHE;
    assign rd_maint = rd && (req.coprocessor_reg_number == REG_CACHE ||
                             req.coprocessor_reg_number == REG_TLB);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_read_answer;
        rd |=> rsp.valid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read request got no answer");
    property p_no_stray_answer;
        rsp.valid |-> $past(rd);
    endproperty
    a_no_stray_answer: assert property (p_no_stray_answer)
        else $error("answer without a read");
    property p_xlate;
        wr_ctrl |=> cfg.xlate_on == $past(req.wdata[SC_XLATE]);
    endproperty
    a_xlate: assert property (p_xlate)
        else $error("translation enable not taken");
    property p_desc;
        wr_ctrl |=> cfg.descriptor_format_select == $past(req.wdata[SC_DESC]);
    endproperty
    a_desc: assert property (p_desc)
        else $error("descriptor format not taken");
    property p_tlb_op;
        wr_tlb && req.op2 <= OP2_2 |=> tlb_cmd.valid && tlb_cmd.op == $past(req.op2);
    endproperty
    a_tlb_op: assert property (p_tlb_op)
        else $error("tlb command missing");
    property p_tlb_refuse;
        wr_tlb && req.op2 > OP2_2 |=> !tlb_cmd.valid;
    endproperty
    a_tlb_refuse: assert property (p_tlb_refuse)
        else $error("tlb command on bad selector");
    property p_cache_cmd;
        wr_cache |=> cache_cmd.valid && cache_cmd.arg == $past(req.wdata);
    endproperty
    a_cache_cmd: assert property (p_cache_cmd)
        else $error("cache command missing");
    property p_maint_read;
        rd_maint |=> rsp.rdata == ZERO32;
    endproperty
    a_maint_read: assert property (p_maint_read)
        else $error("maintenance read not zero");
    property p_base_zero;
        lookup_addr == ZERO32 |=> !use_base_high;
    endproperty
    a_base_zero: assert property (p_base_zero)
        else $error("zero address chose base 1");
endmodule
bind mmu_control_register_set mmu_regs_sva i_mmu_regs_sva (
    .clk(clk),
    .reset(reset),
    .req(req),
    .rsp(rsp),
    .lookup_addr(lookup_addr),
    .use_base_high(use_base_high),
    .cfg(cfg),
    .cache_cmd(cache_cmd),
    .tlb_cmd(tlb_cmd)
);
`default_nettype wire

//--- bench/tb_mmu_control_register_set.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mmu_control_register_set;
    import mmu_regs_pkg::*;
    logic clk;
    logic reset;
    cp_req_t req;
    cp_rsp_t rsp;
    fault_evt_t fault;
    logic [31:0] lookup_addr;
    logic use_base_high;
    logic [31:0] walk_base;
    mmu_cfg_t cfg;
    maint_cmd_t cache_cmd;
    maint_cmd_t tlb_cmd;
    int mismatches = 0;
    int total_checks = 0;
    int pos[8] = '{SC_XLATE, SC_ALIGN, SC_DCACHE, SC_WBUF, SC_ICACHE, SC_DESC, SC_REMAP, SC_AFLAG};
    logic [7:0] sc_bits;
    assign sc_bits = {cfg.xlate_on, cfg.align_check, cfg.dcache_on, cfg.wbuf_on, cfg.icache_on,
                      cfg.descriptor_format_select, cfg.attribute_remap_on, cfg.access_flag_mode};
    mmu_control_register_set i_mmu_control_register_set (.clk(clk), .reset(reset), .req(req),
        .rsp(rsp), .fault(fault), .lookup_addr(lookup_addr), .use_base_high(use_base_high),
        .walk_base(walk_base), .cfg(cfg), .cache_cmd(cache_cmd), .tlb_cmd(tlb_cmd));
    cp_core_model i_cp_core_model (.clk(clk), .rsp(rsp), .req(req));
    always #25 clk = ~clk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] num, input logic [2:0] op2, input logic [31:0] d);
        i_cp_core_model.put(1'b1, num, op2, d);
    endtask
    task automatic rd(input logic [3:0] num, input logic [2:0] op2, input logic [31:0] exp);
        logic [31:0] d;
        bit ok;
        i_cp_core_model.read(num, op2, d, ok);
        if (!ok)
        begin
            mismatches++;
            complete_run();
        end
        else
            chk(d, exp);
    endtask
    task automatic look(input logic [31:0] a, input logic hi);
        @(posedge clk);
        #1;
        lookup_addr = a;
        @(posedge clk);
        #1;
        chk(32'(use_base_high), 32'(hi));
    endtask
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        fault = '0;
        lookup_addr = 32'h0000_0000;
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        rd(REG_CTRL, OP2_0, ZERO32);
        rd(REG_ID, OP2_3, 32'h0008_0800);
        wr(REG_ID, OP2_3, 32'hFFFF_FFFF);
        rd(REG_ID, OP2_3, 32'h0008_0800);
        $display("test reset and geometry done");
        wr(REG_CTRL, OP2_0, 32'hFFFF_FFFF);
        rd(REG_CTRL, OP2_0, SC_WMASK);
        for (int i = 0; i < 8; i++)
        begin
            wr(REG_CTRL, OP2_0, 32'h0000_0001 << pos[i]);
            chk({24'h0, sc_bits}, 32'h0000_0080 >> i);
        end
        wr(REG_CTRL, OP2_1, 32'hFFFF_FFFF);
        rd(REG_CTRL, OP2_1, AUX_WMASK);
        chk(32'(cfg.coherency_member), 32'h1);
        $display("test control done");
        wr(REG_TABLE, OP2_2, 32'hFFFF_FFFF);
        rd(REG_TABLE, OP2_2, 32'h0000_0007);
        // low bits below 14-n are not kept
        wr(REG_TABLE, OP2_0, 32'hFFFF_FFFF);
        rd(REG_TABLE, OP2_0, 32'hFFFF_FF80);
        // table base kept on a 128-byte boundary
        wr(REG_TABLE, OP2_0, 32'hFFFF_FF80);
        rd(REG_TABLE, OP2_0, 32'hFFFF_FF80);
        wr(REG_TABLE, OP2_1, 32'hFFFF_FFFF);
        rd(REG_TABLE, OP2_1, 32'hFFFF_C000);
        look(32'h01FF_FFFF, 1'b0);
        chk(walk_base, 32'hFFFF_FF80);
        look(32'h0200_0000, 1'b1);
        chk(walk_base, 32'hFFFF_C000);
        wr(REG_TABLE, OP2_2, 32'h0000_0000);
        look(32'hFFFF_FFFF, 1'b0);
        wr(REG_TABLE, OP2_0, 32'hFFFF_FFFF);
        rd(REG_TABLE, OP2_0, 32'hFFFF_C000);
        $display("test table base done");
        wr(REG_DOMAIN, OP2_0, 32'hA5C3_5A3C);
        rd(REG_DOMAIN, OP2_0, 32'hA5C3_5A3C);
        chk(cfg.domain_fields, 32'hA5C3_5A3C);
        @(posedge clk);
        #1;
        fault = '{data_abort: 1'b1, fetch_abort: 1'b0, watch_hit: 1'b0, domain: 4'h9,
                  fault_type: 5'h1D, data_addr: 32'h8765_4321, watch_addr: 32'h0000_0000};
        @(posedge clk);
        #1;
        fault = '{data_abort: 1'b0, fetch_abort: 1'b1, watch_hit: 1'b1, domain: 4'h0,
                  fault_type: 5'h1A, data_addr: 32'h0000_0000, watch_addr: 32'h1357_9BDF};
        @(posedge clk);
        #1;
        fault = '0;
        rd(REG_FAULT, OP2_0, 32'h0000_149D);
        rd(REG_ADDR, OP2_0, 32'h8765_4321);
        rd(REG_FAULT, OP2_1, 32'h0000_140A);
        rd(REG_ADDR, OP2_1, 32'h1357_9BDF);
        wr(REG_FAULT, OP2_0, 32'hFFFF_FFFF);
        rd(REG_FAULT, OP2_0, DCAUSE_MASK);
        $display("test faults done");
        wr(REG_CACHE, OP2_0, 32'hC000_0021);
        chk(32'(cache_cmd.valid), 32'h1);
        chk(32'(cache_cmd.op), ZERO32);
        chk(cache_cmd.arg, 32'hC000_0021);
        for (int op = 0; op < 4; op++)
        begin
            wr(REG_TLB, op[2:0], 32'h0000_0042);
            chk(32'(tlb_cmd.valid), {31'h0, op < 3});
            if (op < 3)
            begin
                chk(32'(tlb_cmd.op), op);
                chk(tlb_cmd.arg, 32'h0000_0042);
            end
        end
        rd(REG_CACHE, OP2_0, ZERO32);
        rd(REG_TLB, OP2_0, ZERO32);
        rd(4'h4, OP2_0, ZERO32);
        $display("test maintenance done");
        wr(REG_PIN, OP2_0, 32'hFFFF_FFFF);
        rd(REG_PIN, OP2_0, PIN_MASK);
        chk(32'({cfg.pin_victim, cfg.pin_preserve}), 32'hF);
        wr(REG_PIN, OP2_0, 32'h1400_0000);
        chk(32'({cfg.pin_victim, cfg.pin_preserve}), 32'hA);
        wr(REG_CTX, OP2_1, 32'h1234_5678);
        rd(REG_CTX, OP2_1, 32'h1234_5678);
        chk({cfg.process_tag, cfg.address_space_tag}, 32'h1234_5678);
        wr(REG_CTX, OP2_0, 32'hFFFF_FFFF);
        rd(REG_CTX, OP2_0, RELOC_MASK);
        chk(32'(cfg.process_relocation_field), 32'h0000_007F);
        $display("test pinning and context done");
        // second reset in mid-run clears the set again
        @(posedge clk);
        #1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        rd(REG_CTRL, OP2_0, ZERO32);
        chk(cfg.domain_fields, ZERO32);
        rd(REG_TABLE, OP2_1, ZERO32);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
`default_nettype wire

//--- rtl/mmu_control_register_set.sv
// What this block does
// - geometry reads instr/data lockable counts in byte fields, bit0 split flag
// - control bit0 switches address translation off or on
// - control bit1 enables strict alignment fault checking
// - control bit2 enables level one data cache
// - control bit3 enables write buffer; absent buffer reads one, ignores writes
// - control bit12 enables instruction cache
// - control bit23 picks compatible or extended descriptor format
// - control bit28 remaps page attributes through remap registers
// - control bit29 turns lowest permission bit into access flag
// - auxiliary bit5 places processor inside coherency domain
// - boundary N picks base 0 when top N address bits zero
// - base 0 occupies bits 31 down to 14-N; software aligns table
// - base 1 holds first-level pointer in bits 31 to 14
// - domain register holds sixteen two-bit access fields
// - data abort captures domain in 7:4 and type in bits 12, 10 and 3:0
// - fetch abort captures type in bits 12, 10 and 3:0
// - data fault address and watch hit address captured whole
// - cache maintenance write-only, address or set/way, bit0 selects TCM
// - TLB maintenance write does invalidate all, one, or by tag
// - pinning victim picks lockdown entry; preserve bit protects entries
// - context tag: address space tag low byte, process tag above
// - translation unit also writes fault registers; maintenance reads return zero
`timescale 1ns/1ps
`default_nettype none
module mmu_control_register_set #(
    parameter logic [7:0] INSTR_LOCK_COUNT = 8'h08,
    parameter logic [7:0] DATA_LOCK_COUNT = 8'h08,
    parameter bit SPLIT_TLB = 1'b0,
    parameter bit HAS_WRITE_BUFFER = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire mmu_regs_pkg::cp_req_t req,
    output var mmu_regs_pkg::cp_rsp_t rsp,
    input wire mmu_regs_pkg::fault_evt_t fault,
    input wire logic [31:0] lookup_addr,
    output var logic use_base_high,
    output var logic [31:0] walk_base,
    output var mmu_regs_pkg::mmu_cfg_t cfg,
    output var mmu_regs_pkg::maint_cmd_t cache_cmd,
    output var mmu_regs_pkg::maint_cmd_t tlb_cmd
);
    import mmu_regs_pkg::*;

    logic [31:0] sysctl_q, sysctl_d;
    logic [31:0] aux_q, aux_d;
    logic [31:0] tb0_q, tb0_d;
    logic [31:0] tb1_q, tb1_d;
    logic [31:0] tbsel_q, tbsel_d;
    logic [31:0] dom_q, dom_d;
    logic [31:0] data_abort_cause_q, data_abort_cause_d;
    logic [31:0] fetch_abort_cause_q, fetch_abort_cause_d;
    logic [31:0] data_abort_address_q, data_abort_address_d;
    logic [31:0] watch_hit_address_q, watch_hit_address_d;
    logic [31:0] pin_q, pin_d;
    logic [31:0] reloc_q, reloc_d;
    logic [31:0] ctx_q, ctx_d;
    cp_rsp_t rsp_d;
    maint_cmd_t cache_d, tlb_d;
    mmu_cfg_t cfg_d;
    logic use_high_d;
    logic [31:0] walk_d;
    logic [31:0] geometry;

    function automatic logic hit(input cp_req_t r, input logic [3:0] num,
                                 input logic [2:0] op2);
        hit = r.valid && r.write && r.coprocessor_reg_number == num && r.op2 == op2;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    // mask of address bits kept in base 0 for boundary n
    function automatic logic [31:0] base0_mask(input logic [2:0] n);
        // ones from bit 31 down to 14-n; a right shift would lose the top bits
        base0_mask = ~ZERO32 << (TB_TOP - int'(n));
    endfunction

    always_comb
    begin
        geometry = ZERO32;
        geometry[GEO_INSTR_LSB +: 8] = INSTR_LOCK_COUNT;
        geometry[GEO_DATA_LSB +: 8] = DATA_LOCK_COUNT;
        geometry[GEO_SPLIT] = SPLIT_TLB;
    end

    always_comb
    begin
        sysctl_d = sysctl_q;
        aux_d = aux_q;
        tb0_d = tb0_q;
        tb1_d = tb1_q;
        tbsel_d = tbsel_q;
        dom_d = dom_q;
        data_abort_cause_d = data_abort_cause_q;
        fetch_abort_cause_d = fetch_abort_cause_q;
        data_abort_address_d = data_abort_address_q;
        watch_hit_address_d = watch_hit_address_q;
        pin_d = pin_q;
        reloc_d = reloc_q;
        ctx_d = ctx_q;
        if (hit(req, REG_CTRL, OP2_0))
        begin
            sysctl_d = merge(sysctl_q, req.wdata, SC_WMASK);
        end
        if (!HAS_WRITE_BUFFER)
        begin
            sysctl_d[SC_WBUF] = 1'b1;
        end
        if (hit(req, REG_CTRL, OP2_1))
        begin
            aux_d = merge(aux_q, req.wdata, AUX_WMASK);
        end
        if (hit(req, REG_TABLE, OP2_0))
        begin
            tb0_d = req.wdata & base0_mask(tbsel_q[2:0]);
        end
        if (hit(req, REG_TABLE, OP2_1))
        begin
            tb1_d = req.wdata & TB1_MASK;
        end
        if (hit(req, REG_TABLE, OP2_2))
        begin
            tbsel_d = req.wdata & BOUND_MASK;
        end
        if (hit(req, REG_DOMAIN, OP2_0))
        begin
            dom_d = req.wdata;
        end
        if (hit(req, REG_FAULT, OP2_0))
        begin
            data_abort_cause_d = req.wdata & DCAUSE_MASK;
        end
        if (hit(req, REG_FAULT, OP2_1))
        begin
            fetch_abort_cause_d = req.wdata & FCAUSE_MASK;
        end
        if (hit(req, REG_ADDR, OP2_0))
        begin
            data_abort_address_d = req.wdata;
        end
        if (hit(req, REG_ADDR, OP2_1))
        begin
            watch_hit_address_d = req.wdata;
        end
        if (fault.data_abort)
        begin
            data_abort_cause_d = ZERO32;
            data_abort_cause_d[12:10] = {fault.fault_type[4], 1'b0, fault.fault_type[4]};
            data_abort_cause_d[7:4] = fault.domain;
            data_abort_cause_d[3:0] = fault.fault_type[3:0];
            data_abort_address_d = fault.data_addr;
        end
        if (fault.fetch_abort)
        begin
            fetch_abort_cause_d = ZERO32;
            fetch_abort_cause_d[12] = fault.fault_type[4];
            fetch_abort_cause_d[10] = fault.fault_type[4];
            fetch_abort_cause_d[3:0] = fault.fault_type[3:0];
        end
        if (fault.watch_hit)
        begin
            watch_hit_address_d = fault.watch_addr;
        end
        if (hit(req, REG_PIN, OP2_0))
        begin
            pin_d = req.wdata & PIN_MASK;
        end
        if (hit(req, REG_CTX, OP2_0))
        begin
            reloc_d = req.wdata & RELOC_MASK;
        end
        if (hit(req, REG_CTX, OP2_1))
        begin
            ctx_d = req.wdata;
        end
    end

    // read path; maintenance registers read zero
    always_comb
    begin
        rsp_d = '0;
        rsp_d.valid = req.valid && !req.write;
        if (req.valid && !req.write)
        begin
            unique case (req.coprocessor_reg_number)
                REG_ID:
                begin
                    rsp_d.rdata = (req.op2 == OP2_3) ? geometry : ZERO32;
                end
                REG_CTRL:
                begin
                    rsp_d.rdata = (req.op2 == OP2_1) ? aux_q : sysctl_q;
                end
                REG_TABLE:
                begin
                    rsp_d.rdata = (req.op2 == OP2_0) ? tb0_q :
                                  (req.op2 == OP2_1) ? tb1_q : tbsel_q;
                end
                REG_DOMAIN:
                begin
                    rsp_d.rdata = dom_q;
                end
                REG_FAULT:
                begin
                    rsp_d.rdata = (req.op2 == OP2_1) ? fetch_abort_cause_q :
                                  data_abort_cause_q;
                end
                REG_ADDR:
                begin
                    rsp_d.rdata = (req.op2 == OP2_1) ? watch_hit_address_q :
                                  data_abort_address_q;
                end
                REG_PIN:
                begin
                    rsp_d.rdata = pin_q;
                end
                REG_CTX:
                begin
                    rsp_d.rdata = (req.op2 == OP2_1) ? ctx_q : reloc_q;
                end
                default:
                begin
                    rsp_d.rdata = ZERO32;
                end
            endcase
        end
    end

    // maintenance command pulses
    always_comb
    begin
        cache_d = '0;
        tlb_d = '0;
        if (req.valid && req.write && req.coprocessor_reg_number == REG_CACHE)
        begin
            cache_d.valid = 1'b1;
            cache_d.op = req.op2;
            cache_d.arg = req.wdata;
        end
        if (req.valid && req.write && req.coprocessor_reg_number == REG_TLB &&
            (req.op2 == OP2_0 || req.op2 == OP2_1 || req.op2 == OP2_2))
        begin
            tlb_d.valid = 1'b1;
            tlb_d.op = req.op2;
            tlb_d.arg = req.wdata;
        end
    end

    always_comb
    begin
        logic [31:0] top_mask;
        top_mask = ~(32'hFFFF_FFFF >> tbsel_q[2:0]);
        use_high_d = (tbsel_q[2:0] != 3'h0) && ((lookup_addr & top_mask) != ZERO32);
        walk_d = use_high_d ? tb1_q : tb0_q;
    end

    always_comb
    begin
        cfg_d.xlate_on = sysctl_d[SC_XLATE];
        cfg_d.align_check = sysctl_d[SC_ALIGN];
        cfg_d.dcache_on = sysctl_d[SC_DCACHE];
        cfg_d.wbuf_on = sysctl_d[SC_WBUF] && HAS_WRITE_BUFFER;
        cfg_d.icache_on = sysctl_d[SC_ICACHE];
        cfg_d.descriptor_format_select = sysctl_d[SC_DESC];
        cfg_d.attribute_remap_on = sysctl_d[SC_REMAP];
        cfg_d.access_flag_mode = sysctl_d[SC_AFLAG];
        cfg_d.coherency_member = aux_d[AUX_COHERENT];
        cfg_d.domain_fields = dom_d;
        cfg_d.address_space_tag = ctx_d[7:0];
        cfg_d.process_tag = ctx_d[31:8];
        cfg_d.process_relocation_field = reloc_d[31:25];
        cfg_d.pin_victim = pin_d[PIN_VICTIM_LSB +: 3];
        cfg_d.pin_preserve = pin_d[PIN_PRESERVE];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sysctl_q <= HAS_WRITE_BUFFER ? ZERO32 : 32'h0000_0008;
            aux_q <= ZERO32;
            tb0_q <= ZERO32;
            tb1_q <= ZERO32;
            tbsel_q <= ZERO32;
            dom_q <= ZERO32;
            data_abort_cause_q <= ZERO32;
            fetch_abort_cause_q <= ZERO32;
            data_abort_address_q <= ZERO32;
            watch_hit_address_q <= ZERO32;
            pin_q <= ZERO32;
            reloc_q <= ZERO32;
            ctx_q <= ZERO32;
            rsp <= '0;
            cache_cmd <= '0;
            tlb_cmd <= '0;
            cfg <= '0;
            use_base_high <= 1'b0;
            walk_base <= ZERO32;
        end
        else
        begin
            sysctl_q <= sysctl_d;
            aux_q <= aux_d;
            tb0_q <= tb0_d;
            tb1_q <= tb1_d;
            tbsel_q <= tbsel_d;
            dom_q <= dom_d;
            data_abort_cause_q <= data_abort_cause_d;
            fetch_abort_cause_q <= fetch_abort_cause_d;
            data_abort_address_q <= data_abort_address_d;
            watch_hit_address_q <= watch_hit_address_d;
            pin_q <= pin_d;
            reloc_q <= reloc_d;
            ctx_q <= ctx_d;
            rsp <= rsp_d;
            cache_cmd <= cache_d;
            tlb_cmd <= tlb_d;
            cfg <= cfg_d;
            use_base_high <= use_high_d;
            walk_base <= walk_d;
        end
    end
endmodule
`default_nettype wire

//--- rtl/mmu_regs_pkg.sv
package mmu_regs_pkg;
    // coprocessor register numbers
    localparam logic [3:0] REG_ID = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h1;
    localparam logic [3:0] REG_TABLE = 4'h2;
    localparam logic [3:0] REG_DOMAIN = 4'h3;
    localparam logic [3:0] REG_FAULT = 4'h5;
    localparam logic [3:0] REG_ADDR = 4'h6;
    localparam logic [3:0] REG_CACHE = 4'h7;
    localparam logic [3:0] REG_TLB = 4'h8;
    localparam logic [3:0] REG_PIN = 4'hA;
    localparam logic [3:0] REG_CTX = 4'hD;
    // second opcode selectors
    localparam logic [2:0] OP2_0 = 3'h0;
    localparam logic [2:0] OP2_1 = 3'h1;
    localparam logic [2:0] OP2_2 = 3'h2;
    localparam logic [2:0] OP2_3 = 3'h3;
    // system control bit positions
    localparam int SC_XLATE = 0;
    localparam int SC_ALIGN = 1;
    localparam int SC_DCACHE = 2;
    localparam int SC_WBUF = 3;
    localparam int SC_ICACHE = 12;
    localparam int SC_DESC = 23;
    localparam int SC_REMAP = 28;
    localparam int SC_AFLAG = 29;
    localparam logic [31:0] SC_WMASK = 32'h3080_100F;
    localparam int AUX_COHERENT = 5;
    localparam logic [31:0] AUX_WMASK = 32'h0000_0020;
    // geometry fields
    localparam int GEO_INSTR_LSB = 16;
    localparam int GEO_DATA_LSB = 8;
    localparam int GEO_SPLIT = 0;
    // table base
    localparam int TB_TOP = 14;
    localparam logic [31:0] TB1_MASK = 32'hFFFF_C000;
    localparam logic [31:0] BOUND_MASK = 32'h0000_0007;
    // fault status writable bits
    localparam logic [31:0] DCAUSE_MASK = 32'h0000_1CFF;
    localparam logic [31:0] FCAUSE_MASK = 32'h0000_140F;
    // pinning
    localparam logic [31:0] PIN_MASK = 32'h1C00_0001;
    localparam int PIN_VICTIM_LSB = 26;
    localparam int PIN_PRESERVE = 0;
    localparam logic [31:0] RELOC_MASK = 32'hFE00_0000;
    localparam int CACHE_TCM = 0;
    localparam int CACHE_WAY_LSB = 30;
    localparam int CACHE_ADDR_LSB = 5;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] coprocessor_reg_number;
        logic [3:0] crm;
        logic [2:0] op2;
        logic [31:0] wdata;
    } cp_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } cp_rsp_t;

    typedef struct packed {
        logic data_abort;
        logic fetch_abort;
        logic watch_hit;
        logic [3:0] domain;
        logic [4:0] fault_type;
        logic [31:0] data_addr;
        logic [31:0] watch_addr;
    } fault_evt_t;

    typedef struct packed {
        logic valid;
        logic [2:0] op;
        logic [31:0] arg;
    } maint_cmd_t;

    typedef struct packed {
        logic xlate_on;
        logic align_check;
        logic dcache_on;
        logic wbuf_on;
        logic icache_on;
        logic descriptor_format_select;
        logic attribute_remap_on;
        logic access_flag_mode;
        logic coherency_member;
        logic [31:0] domain_fields;
        logic [7:0] address_space_tag;
        logic [23:0] process_tag;
        logic [6:0] process_relocation_field;
        logic [2:0] pin_victim;
        logic pin_preserve;
    } mmu_cfg_t;

    typedef enum logic [1:0] {
        RSP_IDLE,
        RSP_HOLD
    } rsp_state_t;
endpackage
